// [verilog/inposition_and_speed_select.sv]
module inposition_and_speed_select
  import settle_pkg::*;
#(
  parameter int unsigned MS_TICK_CYCLES = settle_pkg::MS_CYCLES
) (
  input  wire logic                          clk,
  input  wire logic                          resetn,
  input  wire logic [settle_pkg::AW-1:0]     reg_addr,
  input  wire logic [settle_pkg::DW-1:0]     reg_wdata,
  input  wire logic                          reg_we,
  input  wire logic                          reg_re,
  output logic      [settle_pkg::DW-1:0]     reg_rdata,
  input  wire logic                          nv_output_format,
  input  wire settle_pkg::ctrl_mode_t        ctrl_mode,
  input  wire logic [settle_pkg::DEV_W-1:0]  deviation_scaled,
  input  wire logic [settle_pkg::DEV_W-1:0]  deviation_raw,
  input  wire logic [settle_pkg::RPM_W-1:0]  motor_speed,
  input  wire logic                          cmd_queue_empty,
  input  wire logic [settle_pkg::TIME_W-1:0] entry_accel_time,
  input  wire logic [settle_pkg::TIME_W-1:0] entry_decel_time,
  input  wire logic                          ramp_set_select,
  input  wire logic                          speed_select_bit0,
  input  wire logic                          speed_select_bit1,
  input  wire logic                          speed_select_bit2,
  input  wire logic [settle_pkg::SPD_W-1:0]  analog_speed_ref,
  output logic [settle_pkg::TERM_N-1:0]      general_output_terminal,
  output logic                               position_settled_flag,
  output logic                               ramp_active,
  output logic [settle_pkg::TIME_W-1:0]      accel_time_out,
  output logic [settle_pkg::TIME_W-1:0]      decel_time_out,
  output logic [settle_pkg::SPD_W-1:0]       speed_ref_out
);
  import settle_pkg::*;

  logic                deviation_unit_select_q;
  logic [DEV_W-1:0]    deviation_range_value_q;
  logic [RPM_W-1:0]    zero_speed_range_value_q;
  logic [MS_W-1:0]     settled_pulse_or_min_off_time_q;
  logic [MS_W-1:0]     settled_judgment_time_q;
  logic                speed_ramp_enable_q;
  logic [TIME_W-1:0]   accel_time_set1_q;
  logic [TIME_W-1:0]   decel_time_set1_q;
  logic [TIME_W-1:0]   accel_time_set2_q;
  logic [TIME_W-1:0]   decel_time_set2_q;
  logic [SPD_W-1:0]    preset_speed_q [PRESET_N];
  logic                torque_speed_limit_select_q;
  logic [SPD_W-1:0]    torque_mode_max_speed_q;
  logic [7:0]          term_map_q;
  logic                settled_output_format_q;
  logic                format_loaded_q;
  logic [31:0]         tick_cnt_q;
  logic                ms_tick;
  logic [DEV_W-1:0]    dev_sel;
  logic                zero_dev;
  logic                raw_settled;
  logic [MS_W-1:0]     judge_cnt_q;
  logic                recog_q;
  logic                recog_prev_q;
  logic [MS_W-1:0]     out_cnt_q;
  logic                settled_d;
  logic                zero_dev_q;
  logic [2:0]          step_code;
  logic                ramp_d;
  logic                set2;
  logic [TIME_W-1:0]   acc_sel;
  logic [TIME_W-1:0]   dec_sel;
  logic [SPD_W-1:0]    speed_d;

  // millisecond time base; slow count is a parameter for simulation
  // the ms count runs free, so a timed span may be one tick short
  assign ms_tick = (tick_cnt_q == MS_TICK_CYCLES - 1);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tick_cnt_q <= 32'h0000_0000;
    end else if (ms_tick) begin
      tick_cnt_q <= 32'h0000_0000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
    end
  end

  // parameter registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      deviation_unit_select_q         <= UNIT_SCALED;
      deviation_range_value_q         <= RST_DEV_RANGE;
      zero_speed_range_value_q        <= RST_ZSPD_RANGE;
      settled_pulse_or_min_off_time_q <= RST_PULSE_TIME;
      settled_judgment_time_q         <= RST_JUDGE_TIME;
      speed_ramp_enable_q             <= 1'b0;
      accel_time_set1_q               <= RST_ACC1;
      decel_time_set1_q               <= RST_DEC1;
      accel_time_set2_q               <= RST_ACC2;
      decel_time_set2_q               <= RST_DEC2;
      torque_speed_limit_select_q     <= TLIM_MAX;
      torque_mode_max_speed_q         <= RST_TQ_MAXSPD;
      term_map_q                      <= RST_TERM_MAP;
    end else if (reg_we) begin
      unique case (reg_addr)
        REG_DEV_UNIT:   deviation_unit_select_q <= reg_wdata[0];
        REG_DEV_RANGE:  deviation_range_value_q <= reg_wdata[DEV_W-1:0];
        REG_ZSPD_RANGE: zero_speed_range_value_q <= reg_wdata[RPM_W-1:0];
        REG_PULSE_TIME: settled_pulse_or_min_off_time_q <= reg_wdata[MS_W-1:0];
        REG_JUDGE_TIME: settled_judgment_time_q <= reg_wdata[MS_W-1:0];
        REG_RAMP_EN:    speed_ramp_enable_q <= reg_wdata[0];
        REG_ACC1:       accel_time_set1_q <= reg_wdata[TIME_W-1:0];
        REG_DEC1:       decel_time_set1_q <= reg_wdata[TIME_W-1:0];
        REG_ACC2:       accel_time_set2_q <= reg_wdata[TIME_W-1:0];
        REG_DEC2:       decel_time_set2_q <= reg_wdata[TIME_W-1:0];
        REG_TLIM_SEL:   torque_speed_limit_select_q <= reg_wdata[0];
        REG_TQ_MAXSPD:  torque_mode_max_speed_q <= reg_wdata[SPD_W-1:0];
        REG_TERM_MAP:   term_map_q <= reg_wdata[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < PRESET_N; i++) begin
        preset_speed_q[i] <= RST_PRESET_LO;
      end
      preset_speed_q[1] <= RST_PRESET2;
      preset_speed_q[2] <= RST_PRESET3;
    end else if (reg_we) begin
      for (int i = 0; i < PRESET_N; i++) begin
        if (reg_addr == REG_PRESET1 + AW'(i)) begin
          preset_speed_q[i] <= reg_wdata[SPD_W-1:0];
        end
      end
    end
  end

  // a later change of the stored format waits for the next reset
  // format latched once after each reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      settled_output_format_q <= FMT_LEVEL;
      format_loaded_q         <= 1'b0;
    end else if (!format_loaded_q) begin
      settled_output_format_q <= nv_output_format;
      format_loaded_q         <= 1'b1;
    end
  end

  assign dev_sel = (deviation_unit_select_q == UNIT_PULSE) ? deviation_raw : deviation_scaled;
  assign zero_dev = (dev_sel <= deviation_range_value_q);

  always_comb begin
    raw_settled = zero_dev && (motor_speed <= zero_speed_range_value_q);
    if (ctrl_mode == MODE_INT_POS && !cmd_queue_empty) begin
      raw_settled = 1'b0;
    end
  end

  // the count moves on ms ticks, so the delay is within one tick
  // judgment delay, zero recognises next cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      judge_cnt_q <= '0;
      recog_q     <= 1'b0;
    end else if (!raw_settled) begin
      judge_cnt_q <= '0;
      recog_q     <= 1'b0;
    end else if (judge_cnt_q >= settled_judgment_time_q) begin
      recog_q     <= 1'b1;
    end else if (ms_tick) begin
      judge_cnt_q <= judge_cnt_q + MS_W'(1);
    end
  end

  // out_cnt_q counts off time in level format, on time in single shot
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      recog_prev_q <= 1'b0;
      out_cnt_q    <= '0;
    end else begin
      recog_prev_q <= recog_q;
      if (settled_output_format_q == FMT_SHOT) begin
        if (recog_q && !recog_prev_q) begin
          out_cnt_q <= '0;
        end else if (position_settled_flag && ms_tick) begin
          out_cnt_q <= out_cnt_q + MS_W'(1);
        end
      end else begin
        // off time counted while output is off
        if (position_settled_flag) begin
          out_cnt_q <= '0;
        end else if (ms_tick && out_cnt_q < settled_pulse_or_min_off_time_q) begin
          out_cnt_q <= out_cnt_q + MS_W'(1);
        end
      end
    end
  end

  always_comb begin
    if (settled_output_format_q == FMT_SHOT) begin
      if (recog_q && !recog_prev_q) begin
        settled_d = 1'b1;
      end else begin
        settled_d = position_settled_flag &&
                    !(ms_tick && out_cnt_q + MS_W'(1) >= settled_pulse_or_min_off_time_q);
      end
    end else if (position_settled_flag) begin
      settled_d = recog_q;
    end else begin
      settled_d = recog_q && (out_cnt_q >= settled_pulse_or_min_off_time_q);
    end
  end

  // the flag is registered so the terminals and the flag agree each cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      position_settled_flag <= 1'b0;
      zero_dev_q            <= 1'b0;
    end else begin
      position_settled_flag <= settled_d;
      zero_dev_q            <= zero_dev;
    end
  end

  // routed from settled_d so a terminal never lags the registered flag
  // terminal routing, settled wins a shared terminal
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      general_output_terminal <= '0;
    end else begin
      for (int t = 0; t < TERM_N; t++) begin
        general_output_terminal[t] <=
          (term_map_q[MAP_ST_EN] && term_map_q[MAP_ST_POS +: TERM_W] == TERM_W'(t)) ?
            settled_d :
          (term_map_q[MAP_ZD_EN] && term_map_q[MAP_ZD_POS +: TERM_W] == TERM_W'(t)) ?
            zero_dev : 1'b0;
      end
    end
  end

  // ramp selection
  // entry times exist only for internal moves, other modes ignore them
  assign set2 = ramp_set_select;

  always_comb begin
    unique case (ctrl_mode)
      MODE_PULSE:   ramp_d = 1'b0;
      MODE_INT_POS: ramp_d = 1'b1;
      MODE_SPEED:   ramp_d = speed_ramp_enable_q;
      MODE_TORQUE:  ramp_d = speed_ramp_enable_q;
    endcase
    // set chosen by input, times per 2000 r/min
    acc_sel = set2 ? accel_time_set2_q : accel_time_set1_q;
    dec_sel = set2 ? decel_time_set2_q : decel_time_set1_q;
    // zero entry falls back to parameters
    if (ctrl_mode == MODE_INT_POS && entry_accel_time != '0) begin
      acc_sel = entry_accel_time;
    end
    if (ctrl_mode == MODE_INT_POS && entry_decel_time != '0) begin
      dec_sel = entry_decel_time;
    end
    if (!ramp_d) begin
      acc_sel = '0;
      dec_sel = '0;
    end
  end

  // speed reference and torque limit
  // analog reference passes unscaled; the host owns its scale
  assign step_code = {speed_select_bit2, speed_select_bit1, speed_select_bit0};

  always_comb begin
    if (step_code == 3'h0) begin
      speed_d = analog_speed_ref;
    end else begin
      speed_d = preset_speed_q[step_code - 3'h1];
    end
    if (ctrl_mode == MODE_TORQUE && torque_speed_limit_select_q == TLIM_MAX) begin
      speed_d = torque_mode_max_speed_q;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ramp_active    <= 1'b0;
      accel_time_out <= '0;
      decel_time_out <= '0;
      speed_ref_out  <= '0;
    end else begin
      ramp_active    <= ramp_d;
      accel_time_out <= acc_sel;
      decel_time_out <= dec_sel;
      speed_ref_out  <= speed_d;
    end
  end

  // register read, unmapped reads give zero
  // format reads the latched value, so software sees what runs
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= '0;
    end else if (reg_re) begin
      reg_rdata <= '0;
      unique case (reg_addr)
        REG_DEV_UNIT:   reg_rdata[0] <= deviation_unit_select_q;
        REG_DEV_RANGE:  reg_rdata <= deviation_range_value_q;
        REG_ZSPD_RANGE: reg_rdata[RPM_W-1:0] <= zero_speed_range_value_q;
        REG_FORMAT:     reg_rdata[0] <= settled_output_format_q;
        REG_PULSE_TIME: reg_rdata[MS_W-1:0] <= settled_pulse_or_min_off_time_q;
        REG_JUDGE_TIME: reg_rdata[MS_W-1:0] <= settled_judgment_time_q;
        REG_RAMP_EN:    reg_rdata[0] <= speed_ramp_enable_q;
        REG_ACC1:       reg_rdata[TIME_W-1:0] <= accel_time_set1_q;
        REG_DEC1:       reg_rdata[TIME_W-1:0] <= decel_time_set1_q;
        REG_ACC2:       reg_rdata[TIME_W-1:0] <= accel_time_set2_q;
        REG_DEC2:       reg_rdata[TIME_W-1:0] <= decel_time_set2_q;
        REG_TLIM_SEL:   reg_rdata[0] <= torque_speed_limit_select_q;
        REG_TQ_MAXSPD:  reg_rdata[SPD_W-1:0] <= torque_mode_max_speed_q;
        REG_TERM_MAP:   reg_rdata[7:0] <= term_map_q;
        REG_STATUS: begin
          reg_rdata[ST_ZDEV]    <= zero_dev_q;
          reg_rdata[ST_RECOG]   <= recog_q;
          reg_rdata[ST_SETTLED] <= position_settled_flag;
          reg_rdata[ST_FORMAT]  <= settled_output_format_q;
          reg_rdata[ST_RAMP]    <= ramp_active;
        end
        default: begin
          for (int i = 0; i < PRESET_N; i++) begin
            if (reg_addr == REG_PRESET1 + AW'(i)) begin
              reg_rdata[SPD_W-1:0] <= preset_speed_q[i];
            end
          end
        end
      endcase
    end
  end

endmodule // inposition_and_speed_select

// [verilog/settle_pkg.sv]
package settle_pkg;
  // clock and time base
  localparam int unsigned CLK_HZ       = 200_000_000;
  localparam int unsigned MS_PER_S     = 1000;
  localparam int unsigned TICK_MS      = 1;
  localparam int unsigned MS_CYCLES    = CLK_HZ / MS_PER_S * TICK_MS;

  // widths
  localparam int unsigned AW           = 5;
  localparam int unsigned DW           = 32;
  localparam int unsigned DEV_W        = 32;
  localparam int unsigned SPD_W        = 24;
  localparam int unsigned RPM_W        = 16;
  localparam int unsigned TIME_W       = 20;
  localparam int unsigned MS_W         = 10;
  localparam int unsigned TERM_N       = 8;
  localparam int unsigned TERM_W       = 3;
  localparam int unsigned PRESET_N     = 7;

  typedef enum logic [1:0] {
    MODE_PULSE,
    MODE_INT_POS,
    MODE_SPEED,
    MODE_TORQUE
  } ctrl_mode_t;

  // register word addresses
  localparam logic [AW-1:0] REG_DEV_UNIT   = 5'h00;
  localparam logic [AW-1:0] REG_DEV_RANGE  = 5'h01;
  localparam logic [AW-1:0] REG_ZSPD_RANGE = 5'h02;
  localparam logic [AW-1:0] REG_FORMAT     = 5'h03;
  localparam logic [AW-1:0] REG_PULSE_TIME = 5'h04;
  localparam logic [AW-1:0] REG_JUDGE_TIME = 5'h05;
  localparam logic [AW-1:0] REG_RAMP_EN    = 5'h06;
  localparam logic [AW-1:0] REG_ACC1       = 5'h07;
  localparam logic [AW-1:0] REG_DEC1       = 5'h08;
  localparam logic [AW-1:0] REG_ACC2       = 5'h09;
  localparam logic [AW-1:0] REG_DEC2       = 5'h0A;
  localparam logic [AW-1:0] REG_PRESET1    = 5'h0B;
  localparam logic [AW-1:0] REG_TLIM_SEL   = 5'h12;
  localparam logic [AW-1:0] REG_TQ_MAXSPD  = 5'h13;
  localparam logic [AW-1:0] REG_STATUS     = 5'h14;
  localparam logic [AW-1:0] REG_TERM_MAP   = 5'h15;

  // terminal map fields
  localparam int unsigned MAP_ZD_POS   = 0;
  localparam int unsigned MAP_ZD_EN    = 3;
  localparam int unsigned MAP_ST_POS   = 4;
  localparam int unsigned MAP_ST_EN    = 7;

  // status fields
  localparam int unsigned ST_ZDEV      = 0;
  localparam int unsigned ST_RECOG     = 1;
  localparam int unsigned ST_SETTLED   = 2;
  localparam int unsigned ST_FORMAT    = 3;
  localparam int unsigned ST_RAMP      = 4;

  // deviation unit, output format and torque limit codes
  localparam logic UNIT_SCALED = 1'b0;
  localparam logic UNIT_PULSE  = 1'b1;
  localparam logic FMT_LEVEL   = 1'b0;
  localparam logic FMT_SHOT    = 1'b1;
  localparam logic TLIM_MAX    = 1'b0;

  // reset values (pulse and judgment times in ms ticks, speeds in 0.01 r/min)
  localparam logic [DEV_W-1:0]  RST_DEV_RANGE  = 32'h0000_0064;
  localparam logic [RPM_W-1:0]  RST_ZSPD_RANGE = 16'h0032;
  localparam logic [MS_W-1:0]   RST_PULSE_TIME = 10'h014;
  localparam logic [MS_W-1:0]   RST_JUDGE_TIME = 10'h000;
  localparam logic [TIME_W-1:0] RST_ACC1       = 20'h003E8;
  localparam logic [TIME_W-1:0] RST_DEC1       = 20'h003E8;
  localparam logic [TIME_W-1:0] RST_ACC2       = 20'h01388;
  localparam logic [TIME_W-1:0] RST_DEC2       = 20'h01388;
  localparam logic [SPD_W-1:0]  RST_PRESET_LO  = 24'h002710;
  localparam logic [SPD_W-1:0]  RST_PRESET2    = 24'h00C350;
  localparam logic [SPD_W-1:0]  RST_PRESET3    = 24'h0186A0;
  localparam logic [SPD_W-1:0]  RST_TQ_MAXSPD  = 24'h0493E0;
  localparam logic [7:0]        RST_TERM_MAP   = 8'h98;
endpackage

// [verif/settle_chk.sv]
module settle_chk
  import settle_pkg::*;
#(
  parameter int unsigned MS_TICK_CYCLES = 10
) (
  input wire logic                          clk,
  input wire logic                          resetn,
  input wire settle_pkg::ctrl_mode_t        ctrl_mode,
  input wire logic [settle_pkg::RPM_W-1:0]  motor_speed,
  input wire logic                          cmd_queue_empty,
  input wire logic [settle_pkg::TIME_W-1:0] entry_accel_time,
  input wire logic [settle_pkg::TIME_W-1:0] entry_decel_time,
  input wire logic                          ramp_set_select,
  input wire logic                          speed_select_bit0,
  input wire logic                          speed_select_bit1,
  input wire logic                          speed_select_bit2,
  input wire logic [settle_pkg::SPD_W-1:0]  analog_speed_ref,
  input wire logic [settle_pkg::TERM_N-1:0] general_output_terminal,
  input wire logic                          position_settled_flag,
  input wire logic                          ramp_active,
  input wire logic [settle_pkg::TIME_W-1:0] accel_time_out,
  input wire logic [settle_pkg::TIME_W-1:0] decel_time_out,
  input wire logic [settle_pkg::SPD_W-1:0]  speed_ref_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] code;
  assign code = {speed_select_bit2, speed_select_bit1, speed_select_bit0};

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  speed_analog_a: assert property (
    ($past(resetn) && $past(ctrl_mode) == MODE_SPEED && $past(code) == 3'h0)
      |-> speed_ref_out == $past(analog_speed_ref)) else $error("analog reference not selected");
  pulse_noramp_a: assert property (
    $past(resetn) && $past(ctrl_mode) == MODE_PULSE |-> !ramp_active && accel_time_out == '0)
    else $error("ramp applied under pulse operation");
  intpos_ramp_a: assert property (
    $past(resetn) && $past(ctrl_mode) == MODE_INT_POS |-> ramp_active)
    else $error("internal move without ramp");
  entry_override_a: assert property (
    ($past(resetn) && $past(ctrl_mode) == MODE_INT_POS && $past(entry_decel_time) != '0)
      |-> decel_time_out == $past(entry_decel_time)) else $error("entry time not used");
  default_set_a: assert property (
    ($past(resetn) && $past(ctrl_mode) == MODE_INT_POS && $past(entry_accel_time) == '0)
      |-> accel_time_out == ($past(ramp_set_select) ? RST_ACC2 : RST_ACC1))
    else $error("wrong ramp set selected");
  noramp_zero_a: assert property (
    !ramp_active |-> accel_time_out == '0 && decel_time_out == '0)
    else $error("ramp times shown while ramp off");
  queue_gate_a: assert property (
    $rose(position_settled_flag)
      |-> $past(cmd_queue_empty, 2) || $past(ctrl_mode, 2) != MODE_INT_POS)
    else $error("settled with pulses still queued");
  zero_speed_a: assert property (
    $rose(position_settled_flag) |-> $past(motor_speed, 2) <= RST_ZSPD_RANGE)
    else $error("settled while motor moving");
  route_settled_a: assert property (
    general_output_terminal[1] == position_settled_flag) else $error("settled terminal mismatch");
endmodule // settle_chk

bind inposition_and_speed_select settle_chk #(.MS_TICK_CYCLES(MS_TICK_CYCLES)) settle_chk_inst (
  .clk(clk), .resetn(resetn), .ctrl_mode(ctrl_mode), .motor_speed(motor_speed),
  .cmd_queue_empty(cmd_queue_empty), .entry_accel_time(entry_accel_time),
  .entry_decel_time(entry_decel_time), .ramp_set_select(ramp_set_select),
  .speed_select_bit0(speed_select_bit0), .speed_select_bit1(speed_select_bit1),
  .speed_select_bit2(speed_select_bit2), .analog_speed_ref(analog_speed_ref),
  .general_output_terminal(general_output_terminal),
  .position_settled_flag(position_settled_flag), .ramp_active(ramp_active),
  .accel_time_out(accel_time_out), .decel_time_out(decel_time_out),
  .speed_ref_out(speed_ref_out));

// [verif/host_terminal_model.sv]
module host_terminal_model (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic [2:0] req_code,
  input  wire logic       req_ramp_set,
  output logic            speed_select_bit0,
  output logic            speed_select_bit1,
  output logic            speed_select_bit2,
  output logic            ramp_set_select
);
  timeunit 1ns;
  timeprecision 100ps;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      {speed_select_bit2, speed_select_bit1, speed_select_bit0} <= 3'h0;
    end else begin
      {speed_select_bit2, speed_select_bit1, speed_select_bit0} <= req_code;
    end
  end
  // set select toggled at any time
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ramp_set_select <= 1'b0;
    end else begin
      ramp_set_select <= req_ramp_set;
    end
  end
endmodule // host_terminal_model

// [verif/inposition_and_speed_select_tb_top.sv]
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin err_count++; \
  $display("Error at %0t: got %h exp %h", $time, got, exp); end end

module inposition_and_speed_select_tb_top
  import settle_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic              clk, resetn, reg_we, reg_re, nv_output_format, cmd_queue_empty, req_ramp;
  logic              ramp_set_select, speed_select_bit0, speed_select_bit1, speed_select_bit2;
  logic              position_settled_flag, ramp_active;
  logic [AW-1:0]     reg_addr;
  logic [DW-1:0]     reg_wdata, reg_rdata, d;
  ctrl_mode_t        ctrl_mode;
  logic [DEV_W-1:0]  deviation_scaled, deviation_raw;
  logic [RPM_W-1:0]  motor_speed;
  logic [TIME_W-1:0] entry_accel_time, entry_decel_time, accel_time_out, decel_time_out;
  logic [SPD_W-1:0]  analog_speed_ref, speed_ref_out;
  logic [SPD_W-1:0]  pre [7];
  logic [TERM_N-1:0] general_output_terminal;
  logic [2:0]        req_code;
  int                err_count, total_checks, n;

  inposition_and_speed_select #(.MS_TICK_CYCLES(10)) inposition_and_speed_select_inst (
    .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
    .nv_output_format(nv_output_format), .ctrl_mode(ctrl_mode),
    .deviation_scaled(deviation_scaled), .deviation_raw(deviation_raw),
    .motor_speed(motor_speed), .cmd_queue_empty(cmd_queue_empty),
    .entry_accel_time(entry_accel_time), .entry_decel_time(entry_decel_time),
    .ramp_set_select(ramp_set_select), .speed_select_bit0(speed_select_bit0),
    .speed_select_bit1(speed_select_bit1), .speed_select_bit2(speed_select_bit2),
    .analog_speed_ref(analog_speed_ref), .general_output_terminal(general_output_terminal),
    .position_settled_flag(position_settled_flag), .ramp_active(ramp_active),
    .accel_time_out(accel_time_out), .decel_time_out(decel_time_out),
    .speed_ref_out(speed_ref_out));

  host_terminal_model host_terminal_model_inst (
    .clk(clk), .resetn(resetn), .req_code(req_code), .req_ramp_set(req_ramp),
    .speed_select_bit0(speed_select_bit0), .speed_select_bit1(speed_select_bit1),
    .speed_select_bit2(speed_select_bit2), .ramp_set_select(ramp_set_select));

  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] v);
    @(posedge clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask

  task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] v);
    @(posedge clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_re <= 1'b0;
    #1;
    v = reg_rdata;
  endtask

  task automatic hold(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask

  // bounded wait, gives the cycles spent
  task automatic wait_flag(input logic v, input int lim, output int k);
    k = 0;
    while (position_settled_flag !== v && k < lim) begin
      @(posedge clk);
      #1;
      k++;
    end
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    #200us;
    err_count++;
    complete_run();
  end

  initial begin
    pre = '{RST_PRESET_LO, RST_PRESET2, RST_PRESET3, RST_PRESET_LO, RST_PRESET_LO,
            RST_PRESET_LO, RST_PRESET_LO};
    {resetn, reg_we, reg_re, nv_output_format, cmd_queue_empty, req_ramp} = 6'h00;
    {reg_addr, reg_wdata, req_code} = '0;
    {entry_accel_time, entry_decel_time} = '0;
    ctrl_mode = MODE_SPEED;
    deviation_scaled = 32'h0000_0005;
    deviation_raw = 32'h0000_01F4;
    motor_speed = 16'h000A;
    analog_speed_ref = 24'h00ABCD;
    err_count = 0;
    total_checks = 0;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    rd(REG_DEV_RANGE, d);
    `CHK(d, 32'h0000_0064)
    wr(REG_FORMAT, 32'h0000_0001);
    rd(REG_FORMAT, d);
    `CHK(d, 32'h0000_0000)
    rd(5'h1F, d);
    `CHK(d, 32'h0000_0000)
    hold(3);
    `CHK(speed_ref_out, analog_speed_ref)
    for (int i = 0; i < PRESET_N; i++) begin
      rd(REG_PRESET1 + 5'(i), d);
      `CHK(d[SPD_W-1:0], pre[i])
      @(posedge clk);
      req_code <= 3'(i + 1);
      hold(3);
      `CHK(speed_ref_out, pre[i])
    end
    `CHK(ramp_active, 1'b0)
    wr(REG_RAMP_EN, 32'h0000_0001);
    hold(2);
    `CHK(accel_time_out, RST_ACC1)
    @(posedge clk);
    req_ramp <= 1'b1;
    hold(3);
    `CHK(decel_time_out, RST_DEC2)
    @(posedge clk);
    req_ramp <= 1'b0;
    ctrl_mode <= MODE_TORQUE;
    req_code <= 3'h2;
    hold(3);
    `CHK(speed_ref_out, RST_TQ_MAXSPD)
    `CHK(ramp_active, 1'b1)
    wr(REG_TLIM_SEL, 32'h0000_0001);
    hold(2);
    `CHK(speed_ref_out, RST_PRESET2)
    @(posedge clk);
    ctrl_mode <= MODE_PULSE;
    hold(2);
    `CHK(accel_time_out, 20'h00000)
    @(posedge clk);
    ctrl_mode <= MODE_INT_POS;
    entry_decel_time <= 20'h00009;
    hold(2);
    `CHK(accel_time_out, RST_ACC1)
    `CHK(decel_time_out, 20'h00009)
    @(posedge clk);
    entry_accel_time <= 20'h00007;
    hold(2);
    `CHK(accel_time_out, 20'h00007)
    // let the minimum off time from reset run out first
    hold(250);
    `CHK(position_settled_flag, 1'b0)
    @(posedge clk);
    cmd_queue_empty <= 1'b1;
    wait_flag(1'b1, 10, n);
    `CHK(n, 2)
    `CHK(general_output_terminal[0], 1'b1)
    wr(REG_PULSE_TIME, 32'h0000_0005);
    wr(REG_DEV_UNIT, 32'h0000_0001);
    hold(4);
    `CHK(position_settled_flag, 1'b0)
    wr(REG_DEV_UNIT, 32'h0000_0000);
    hold(15);
    `CHK(position_settled_flag, 1'b0)
    wait_flag(1'b1, 100, n);
    `CHK(n < 100, 1'b1)
    wr(REG_JUDGE_TIME, 32'h0000_0003);
    @(posedge clk);
    motor_speed <= 16'h00C8;
    hold(100);
    `CHK(position_settled_flag, 1'b0)
    @(posedge clk);
    motor_speed <= 16'h000A;
    hold(15);
    `CHK(position_settled_flag, 1'b0)
    wait_flag(1'b1, 60, n);
    `CHK(n < 60, 1'b1)
    @(posedge clk);
    nv_output_format <= 1'b1;
    rd(REG_STATUS, d);
    `CHK(d[ST_FORMAT], 1'b0)
    @(posedge clk);
    resetn <= 1'b0;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    wait_flag(1'b1, 300, n);
    `CHK(n < 300, 1'b1)
    wait_flag(1'b0, 400, n);
    `CHK(n >= 185 && n <= 215, 1'b1)
    rd(REG_STATUS, d);
    `CHK(d[ST_FORMAT], 1'b1)
    hold(100);
    `CHK(position_settled_flag, 1'b0)
    complete_run();
  end
endmodule // inposition_and_speed_select_tb_top
